// ### core/scl_period_top.sv
// SCL period-count registers of a two-wire bus controller, with the
// master SCL phase timer and the bus idle detector they steer.
// Assumes an APB register port on i_clock and open-drain SCL/SDA pads
// whose levels arrive asynchronously.
//
// Contract
// - Standard high count is 16 bits, sets SCL high cycles, resets to 0x48.
// - Standard low count is 16 bits, sets SCL low cycles, resets to 0x4f.
// - Fast high count is 16 bits, sets fast-mode SCL high, resets to 0x8.
// - Fast low count is 16 bits, sets fast-mode SCL low, resets to 0x17.
// - High-speed preambles use the fast counts, never any high-speed count.
// - Count registers take writes only while the enable flag is 0.
// - A high count written below 6 is stored as 6.
// - A low count written below 8 is stored as 8.
// - Idle is flagged when a 16-bit counter reaches standard high plus 10.
`timescale 1ns/1ns
`default_nettype none
module scl_period_top
    import scl_count_pkg::*;
#(
    parameter int APB_ADDR_WIDTH = 32,
    parameter int APB_DATA_WIDTH = 32
) (
    input  wire logic                      i_clock,
    input  wire logic                      i_rst_n,
    // APB register port
    input  wire logic                      i_psel,
    input  wire logic                      i_penable,
    input  wire logic                      i_pwrite,
    input  wire logic [APB_ADDR_WIDTH-1:0] i_paddr,
    input  wire logic [APB_DATA_WIDTH-1:0] i_pwdata,
    output logic      [APB_DATA_WIDTH-1:0] o_prdata,
    output logic                           o_pready,
    output logic                           o_pslverr,
    // Controller-level controls
    input  wire logic                      i_controller_enable_flag,
    input  wire logic                      i_master_active,
    input  wire logic                      i_fast_mode,
    input  wire logic                      i_hs_preamble,
    // Open-drain bus lines
    input  wire logic                      i_scl,
    output logic                           o_scl_out,
    output logic                           o_scl_oe,
    input  wire logic                      i_sda,
    output logic                           o_bus_idle
);

    // ==========================================================
    // Declarations
    logic [COUNT_WIDTH-1:0]    std_high_count_ff;
    logic [COUNT_WIDTH-1:0]    std_low_count_ff;
    logic [COUNT_WIDTH-1:0]    fast_high_count_ff;
    logic [COUNT_WIDTH-1:0]    fast_low_count_ff;
    logic [COUNT_WIDTH-1:0]    nxt_std_high_count;
    logic [COUNT_WIDTH-1:0]    nxt_std_low_count;
    logic [COUNT_WIDTH-1:0]    nxt_fast_high_count;
    logic [COUNT_WIDTH-1:0]    nxt_fast_low_count;
    logic [COUNT_WIDTH-1:0]    wr_value;
    logic [COUNT_WIDTH-1:0]    wr_high_clamped;
    logic [COUNT_WIDTH-1:0]    wr_low_clamped;
    logic                      wr_access;
    logic                      wr_allowed;

    logic [APB_DATA_WIDTH-1:0] prdata_ff;
    logic [APB_DATA_WIDTH-1:0] nxt_prdata;
    logic                      pslverr_ff;
    logic                      nxt_pslverr;
    logic                      pready_ff;
    logic [COUNT_WIDTH-1:0]    rd_value;
    logic                      addr_hit;
    logic                      setup_phase;

    logic                      scl_meta_ff;
    logic                      scl_sync_ff;
    logic                      sda_meta_ff;
    logic                      sda_sync_ff;

    logic [COUNT_WIDTH-1:0]    sel_high_count;
    logic [COUNT_WIDTH-1:0]    sel_low_count;
    logic                      use_fast;
    logic                      phase_run;
    logic                      scl_oe;
    logic                      bus_idle;
    logic                      scl_oe_ff;
    logic                      bus_idle_ff;
    logic                      scl_out_ff;

    // ==========================================================
    // Pad synchronisers
    // Both lines arrive from outside the clock domain, so each passes
    // two flip-flops before any comparison or counter sees it.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
        end else begin
            scl_meta_ff <= i_scl;
            scl_sync_ff <= scl_meta_ff;
            sda_meta_ff <= i_sda;
            sda_sync_ff <= sda_meta_ff;
        end
    end

    // ==========================================================
    // Write path with minimum clamps
    // Only the low 16 bits of the write data are used; upper bits are
    // dropped because every count register is 16 bits wide.
    always_comb begin
        wr_value   = i_pwdata[COUNT_LSB +: COUNT_WIDTH];
        wr_access  = i_psel && i_penable && i_pwrite;
        wr_allowed = wr_access && !i_controller_enable_flag;
        if (wr_value < HIGH_COUNT_MIN) begin
            wr_high_clamped = HIGH_COUNT_MIN;
        end else begin
            wr_high_clamped = wr_value;
        end
        if (wr_value < LOW_COUNT_MIN) begin
            wr_low_clamped = LOW_COUNT_MIN;
        end else begin
            wr_low_clamped = wr_value;
        end
    end

    // ==========================================================
    // Count register next values
    always_comb begin
        nxt_std_high_count  = std_high_count_ff;
        nxt_std_low_count   = std_low_count_ff;
        nxt_fast_high_count = fast_high_count_ff;
        nxt_fast_low_count  = fast_low_count_ff;
        if (wr_allowed) begin
            case (i_paddr[31:0])
                STD_SCL_HIGH_COUNT_ADDR:  nxt_std_high_count  = wr_high_clamped;
                STD_SCL_LOW_COUNT_ADDR:   nxt_std_low_count   = wr_low_clamped;
                FAST_SCL_HIGH_COUNT_ADDR: nxt_fast_high_count = wr_high_clamped;
                FAST_SCL_LOW_COUNT_ADDR:  nxt_fast_low_count  = wr_low_clamped;
                default: begin
                    nxt_std_high_count = std_high_count_ff;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            std_high_count_ff  <= STD_HIGH_RESET;
            std_low_count_ff   <= STD_LOW_RESET;
            fast_high_count_ff <= FAST_HIGH_RESET;
            fast_low_count_ff  <= FAST_LOW_RESET;
        end else begin
            std_high_count_ff  <= nxt_std_high_count;
            std_low_count_ff   <= nxt_std_low_count;
            fast_high_count_ff <= nxt_fast_high_count;
            fast_low_count_ff  <= nxt_fast_low_count;
        end
    end

    // ==========================================================
    // Read path
    // Read data is captured in the setup phase so that it leaves a
    // flip-flop in the access phase with no wait state.
    always_comb begin
        setup_phase = i_psel && !i_penable;
        addr_hit    = 1'b1;
        case (i_paddr[31:0])
            STD_SCL_HIGH_COUNT_ADDR:  rd_value = std_high_count_ff;
            STD_SCL_LOW_COUNT_ADDR:   rd_value = std_low_count_ff;
            FAST_SCL_HIGH_COUNT_ADDR: rd_value = fast_high_count_ff;
            FAST_SCL_LOW_COUNT_ADDR:  rd_value = fast_low_count_ff;
            default: begin
                rd_value = COUNT_ZERO;
                addr_hit = 1'b0;
            end
        endcase
        nxt_prdata  = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup_phase) begin
            nxt_prdata  = '0;
            nxt_prdata[COUNT_LSB +: COUNT_WIDTH] = rd_value;
            nxt_pslverr = !addr_hit;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
            pready_ff  <= 1'b1;
        end else begin
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
            pready_ff  <= 1'b1;
        end
    end

    // ==========================================================
    // Count selection for the phase timer
    // High-speed mode has no counts of its own here; its preamble runs at
    // fast timing, and the high-speed data phase is outside this block.
    always_comb begin
        use_fast  = i_fast_mode || i_hs_preamble;
        phase_run = i_controller_enable_flag && i_master_active;
        if (use_fast) begin
            sel_high_count = fast_high_count_ff;
            sel_low_count  = fast_low_count_ff;
        end else begin
            sel_high_count = std_high_count_ff;
            sel_low_count  = std_low_count_ff;
        end
    end

    scl_phase_gen u_scl_phase_gen (
        .i_clock      (i_clock),
        .i_rst_n      (i_rst_n),
        .i_run        (phase_run),
        .i_scl_level  (scl_sync_ff),
        .i_high_count (sel_high_count),
        .i_low_count  (sel_low_count),
        .o_scl_oe     (scl_oe)
    );

    bus_idle_detect u_bus_idle_detect (
        .i_clock          (i_clock),
        .i_rst_n          (i_rst_n),
        .i_scl_level      (scl_sync_ff),
        .i_sda_level      (sda_sync_ff),
        .i_std_high_count (std_high_count_ff),
        .o_idle           (bus_idle)
    );

    // ==========================================================
    // Output registers
    // The pad output value is always low: an open-drain line is only
    // ever pulled down, and release is expressed by the enable.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_oe_ff   <= 1'b0;
            bus_idle_ff <= 1'b0;
            scl_out_ff  <= 1'b0;
        end else begin
            scl_oe_ff   <= scl_oe;
            bus_idle_ff <= bus_idle;
            scl_out_ff  <= 1'b0;
        end
    end

    assign o_prdata   = prdata_ff;
    assign o_pready   = pready_ff;
    assign o_pslverr  = pslverr_ff;
    assign o_scl_oe   = scl_oe_ff;
    assign o_scl_out  = scl_out_ff;
    assign o_bus_idle = bus_idle_ff;

endmodule // scl_period_top
`default_nettype wire

// ### inc/scl_count_pkg.sv
// Constants shared by the SCL period-count block and its helpers.
// Assumes a 100 MHz module clock and byte addresses on the register bus.
package scl_count_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [31:0] STD_SCL_HIGH_COUNT_ADDR  = 32'h5000_1314;
    localparam logic [31:0] STD_SCL_LOW_COUNT_ADDR   = 32'h5000_1318;
    localparam logic [31:0] FAST_SCL_HIGH_COUNT_ADDR = 32'h5000_131c;
    localparam logic [31:0] FAST_SCL_LOW_COUNT_ADDR  = 32'h5000_1320;

    // ==========================================================
    // Field layout and values after reset
    localparam int          COUNT_WIDTH        = 16;
    localparam int          COUNT_LSB          = 0;
    localparam logic [15:0] STD_HIGH_RESET     = 16'h0048;
    localparam logic [15:0] STD_LOW_RESET      = 16'h004f;
    localparam logic [15:0] FAST_HIGH_RESET    = 16'h0008;
    localparam logic [15:0] FAST_LOW_RESET     = 16'h0017;

    // ==========================================================
    // Clamps and idle threshold margin, in module clock cycles
    localparam logic [15:0] HIGH_COUNT_MIN     = 16'h0006;
    localparam logic [15:0] LOW_COUNT_MIN      = 16'h0008;
    localparam logic [15:0] IDLE_MARGIN        = 16'h000a;
    localparam logic [15:0] COUNT_ZERO         = 16'h0000;
    localparam logic [15:0] COUNT_ONE          = 16'h0001;

    // ==========================================================
    // Master SCL phase states, one-hot
    typedef enum logic [2:0] {
        PHASE_IDLE = 3'b001,
        PHASE_LOW  = 3'b010,
        PHASE_HIGH = 3'b100
    } phase_state_type;

endpackage

// ### core/scl_phase_gen.sv
// Master SCL phase generator: times low and high phases from counts.
// Assumes a synchronised SCL level and counts already clamped to minima.
`timescale 1ns/1ns
`default_nettype none
module scl_phase_gen
    import scl_count_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_run,
    input  wire logic                   i_scl_level,
    input  wire logic [COUNT_WIDTH-1:0] i_high_count,
    input  wire logic [COUNT_WIDTH-1:0] i_low_count,
    output logic                        o_scl_oe
);

    phase_state_type           state_ff;
    phase_state_type           nxt_state;
    logic [COUNT_WIDTH-1:0]    cnt_ff;
    logic [COUNT_WIDTH-1:0]    nxt_cnt;
    logic                      oe_ff;
    logic                      nxt_oe;

    // ==========================================================
    // Phase sequencing
    // The high phase only counts once SCL is seen high, so a slave
    // that stretches the clock lengthens the phase instead of being cut.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_oe    = oe_ff;
        case (state_ff)
            PHASE_IDLE: begin
                nxt_cnt = COUNT_ZERO;
                nxt_oe  = 1'b0;
                if (i_run) begin
                    nxt_state = PHASE_LOW;
                    nxt_oe    = 1'b1;
                end
            end
            PHASE_LOW: begin
                if (cnt_ff >= i_low_count - COUNT_ONE) begin
                    nxt_cnt   = COUNT_ZERO;
                    nxt_oe    = 1'b0;
                    nxt_state = PHASE_HIGH;
                end else begin
                    nxt_cnt = cnt_ff + COUNT_ONE;
                end
            end
            PHASE_HIGH: begin
                if (!i_run) begin
                    nxt_state = PHASE_IDLE;
                    nxt_cnt   = COUNT_ZERO;
                end else if (i_scl_level) begin
                    if (cnt_ff >= i_high_count - COUNT_ONE) begin
                        nxt_cnt   = COUNT_ZERO;
                        nxt_oe    = 1'b1;
                        nxt_state = PHASE_LOW;
                    end else begin
                        nxt_cnt = cnt_ff + COUNT_ONE;
                    end
                end
            end
            default: begin
                nxt_state = PHASE_IDLE;
                nxt_cnt   = COUNT_ZERO;
                nxt_oe    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= PHASE_IDLE;
            cnt_ff   <= COUNT_ZERO;
            oe_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            oe_ff    <= nxt_oe;
        end
    end

    assign o_scl_oe = oe_ff;

endmodule // scl_phase_gen
`default_nettype wire

// ### core/bus_idle_detect.sv
// Bus idle detector: counts cycles with SCL and SDA both high.
// Assumes synchronised line levels and a high count of at most 65525.
`timescale 1ns/1ns
`default_nettype none
module bus_idle_detect
    import scl_count_pkg::*;
(
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_scl_level,
    input  wire logic                   i_sda_level,
    input  wire logic [COUNT_WIDTH-1:0] i_std_high_count,
    output logic                        o_idle
);

    logic [COUNT_WIDTH-1:0] idle_cnt_ff;
    logic [COUNT_WIDTH-1:0] nxt_idle_cnt;
    logic [COUNT_WIDTH-1:0] threshold;
    logic                   idle_ff;
    logic                   nxt_idle;

    // ==========================================================
    // Idle counting
    // The sum is kept at 16 bits; a high count above 65525 would wrap it,
    // which is why software must keep the count at or below that figure.
    always_comb begin
        threshold    = i_std_high_count + IDLE_MARGIN;
        nxt_idle_cnt = idle_cnt_ff;
        nxt_idle     = idle_ff;
        if (!(i_scl_level && i_sda_level)) begin
            nxt_idle_cnt = COUNT_ZERO;
            nxt_idle     = 1'b0;
        end else if (idle_cnt_ff >= threshold) begin
            nxt_idle = 1'b1;
        end else begin
            nxt_idle_cnt = idle_cnt_ff + COUNT_ONE;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_cnt_ff <= COUNT_ZERO;
            idle_ff     <= 1'b0;
        end else begin
            idle_cnt_ff <= nxt_idle_cnt;
            idle_ff     <= nxt_idle;
        end
    end

    assign o_idle = idle_ff;

endmodule // bus_idle_detect
`default_nettype wire

// ### dv/scl_period_checker.sv
// Checker for scl_period_top: count readback, clamps, SCL low phase, idle.
// Assumes one clock domain and a bind by name onto the top module.
`timescale 1ns/1ns
`default_nettype none
module scl_period_checker
    import scl_count_pkg::*;
#(
    parameter int APB_ADDR_WIDTH = 32,
    parameter int APB_DATA_WIDTH = 32
) (
    input wire logic                      i_clock,
    input wire logic                      i_rst_n,
    input wire logic                      i_psel,
    input wire logic                      i_penable,
    input wire logic                      i_pwrite,
    input wire logic [APB_ADDR_WIDTH-1:0] i_paddr,
    input wire logic [APB_DATA_WIDTH-1:0] i_pwdata,
    input wire logic [APB_DATA_WIDTH-1:0] o_prdata,
    input wire logic                      i_controller_enable_flag,
    input wire logic                      i_fast_mode,
    input wire logic                      i_hs_preamble,
    input wire logic                      i_scl,
    input wire logic                      i_sda,
    input wire logic                      o_scl_oe,
    input wire logic                      o_bus_idle
);
    // Every property runs on the module clock and is off during reset.
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    // ==========================================================
    // Shadow counts and cycle counters
    wire logic [31:0] off = 32'(i_paddr) - STD_SCL_HIGH_COUNT_ADDR;
    wire logic        hit = (off < 32'h10) && (off[1:0] == 2'b00);
    wire logic        rd  = i_psel && i_penable && !i_pwrite;
    logic [15:0] sh_ff [4];
    logic [15:0] nxt_sh [4];
    logic [15:0] oe_cnt_ff, nxt_oe_cnt, idle_cnt_ff, nxt_idle_cnt, floor_v;
    wire logic [15:0] sel_low = (i_fast_mode || i_hs_preamble) ? sh_ff[3] : sh_ff[1];
    wire logic [15:0] idle_at = sh_ff[0] + IDLE_MARGIN;

    // Odd slots are low counts, so their floor is the larger one.
    always_comb begin
        nxt_sh = sh_ff;
        floor_v = off[2] ? LOW_COUNT_MIN : HIGH_COUNT_MIN;
        if (i_psel && i_penable && i_pwrite && hit && !i_controller_enable_flag)
            nxt_sh[off[3:2]] = (i_pwdata[15:0] < floor_v) ? floor_v : i_pwdata[15:0];
        nxt_oe_cnt = o_scl_oe ? oe_cnt_ff + 16'h1 : 16'h0;
        nxt_idle_cnt = (i_scl && i_sda) ? idle_cnt_ff + 16'h1 : 16'h0;
    end

    // Registers only.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_ff <= '{16'h0048, 16'h004f, 16'h0008, 16'h0017};
            oe_cnt_ff <= 16'h0;
            idle_cnt_ff <= 16'h0;
        end else begin
            sh_ff <= nxt_sh;
            oe_cnt_ff <= nxt_oe_cnt;
            idle_cnt_ff <= nxt_idle_cnt;
        end
    end

    // ==========================================================
    // Assertions
    property p_std_high_read;
        rd && hit && off[3:2] == 2'd0 |-> o_prdata == 32'(sh_ff[0]);
    endproperty
    a_std_high_read: assert property (p_std_high_read)
        else $error("std high read");
    property p_std_low_read;
        rd && hit && off[3:2] == 2'd1 |-> o_prdata == 32'(sh_ff[1]);
    endproperty
    a_std_low_read: assert property (p_std_low_read)
        else $error("std low read");
    property p_fast_high_read;
        rd && hit && off[3:2] == 2'd2 |-> o_prdata == 32'(sh_ff[2]);
    endproperty
    a_fast_high_read: assert property (p_fast_high_read)
        else $error("fast high read");
    property p_fast_low_read;
        rd && hit && off[3:2] == 2'd3 |-> o_prdata == 32'(sh_ff[3]);
    endproperty
    a_fast_low_read: assert property (p_fast_low_read)
        else $error("fast low read");
    property p_high_floor;
        rd && hit && !off[2] |-> o_prdata[15:0] >= HIGH_COUNT_MIN;
    endproperty
    a_high_floor: assert property (p_high_floor)
        else $error("high floor");
    property p_low_floor;
        rd && hit && off[2] |-> o_prdata[15:0] >= LOW_COUNT_MIN;
    endproperty
    a_low_floor: assert property (p_low_floor)
        else $error("low floor");
    property p_idle_time;
        $rose(o_bus_idle) |-> idle_cnt_ff > idle_at && idle_cnt_ff <= idle_at + 16'd5;
    endproperty
    a_idle_time: assert property (p_idle_time)
        else $error("idle count");
    property p_low_phase;
        $fell(o_scl_oe) |-> oe_cnt_ff == sel_low;
    endproperty
    a_low_phase: assert property (p_low_phase)
        else $error("low phase");
endmodule // scl_period_checker

bind scl_period_top scl_period_checker #(
    .APB_ADDR_WIDTH(APB_ADDR_WIDTH),
    .APB_DATA_WIDTH(APB_DATA_WIDTH)
) u_scl_period_checker (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .i_controller_enable_flag(i_controller_enable_flag), .i_fast_mode(i_fast_mode),
    .i_hs_preamble(i_hs_preamble), .i_scl(i_scl), .i_sda(i_sda), .o_scl_oe(o_scl_oe),
    .o_bus_idle(o_bus_idle)
);
`default_nettype wire

// ### dv/scl_bus_partner.sv
// Far side of the two-wire bus: pull-ups and a foreign master's SCL.
// Assumes the design's enable pulls SCL low while high.
`timescale 1ns/1ns
`default_nettype none
module scl_bus_partner (
    input  wire logic i_scl_oe,
    input  wire logic i_foreign_run,
    output logic      o_scl,
    output logic      o_sda
);
    logic fg_scl;

    // Foreign master clock, 80 ns period, stands high outside its bursts.
    initial begin
        fg_scl = 1'b1;
        #13;
        forever begin
            #40;
            fg_scl = i_foreign_run ? ~fg_scl : 1'b1;
        end
    end

    // Wired-AND: any party may pull SCL low; SDA is released to its pull-up.
    assign o_scl = !(i_scl_oe || !fg_scl);
    assign o_sda = 1'b1;
endmodule // scl_bus_partner
`default_nettype wire

// ### dv/scl_period_top_tb.sv
// Testbench for scl_period_top: registers over APB, SCL phases, idle.
// Assumes the checker is bound in and the partner models the bus.
`timescale 1ns/1ns
`default_nettype none
module scl_period_top_tb;
    import scl_count_pkg::*;
    logic        clock, rst_n, psel, penable, pwrite, enable, active, fast, hs, foreign;
    logic        scl, sda, pready, pslverr, scl_out, scl_oe, bus_idle, rerr;
    logic [31:0] paddr, pwdata, prdata, rdata;
    int          err_count, comparisons;

    scl_period_top u_scl_period_top (
        .i_clock(clock), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_controller_enable_flag(enable),
        .i_master_active(active), .i_fast_mode(fast), .i_hs_preamble(hs), .i_scl(scl),
        .o_scl_out(scl_out), .o_scl_oe(scl_oe), .i_sda(sda), .o_bus_idle(bus_idle)
    );
    scl_bus_partner u_scl_bus_partner (
        .i_scl_oe(scl_oe), .i_foreign_run(foreign), .o_scl(scl), .o_sda(sda)
    );

    // 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // One APB transfer; pready is constant high, so access lasts one cycle.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, msg);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(STD_SCL_HIGH_COUNT_ADDR, 32'h48, "std high reset");
        rd(STD_SCL_LOW_COUNT_ADDR, 32'h4f, "std low reset");
        rd(FAST_SCL_HIGH_COUNT_ADDR, 32'h8, "fast high reset");
        rd(FAST_SCL_LOW_COUNT_ADDR, 32'h17, "fast low reset");
        $display("test reset_values done");
    endtask

    // Odd slots are low counts (floor 8), even slots high counts (floor 6).
    task automatic t_clamp;
        logic [31:0] a, m;
        for (int i = 0; i < 4; i++) begin
            a = STD_SCL_HIGH_COUNT_ADDR + 32'(4 * i);
            m = i[0] ? 32'h8 : 32'h6;
            apb(1'b1, a, 32'h0);
            rd(a, m, "zero");
            apb(1'b1, a, 32'hffff_0000 | (m - 32'h1));
            rd(a, m, "below floor");
            apb(1'b1, a, m + 32'h1);
            rd(a, m + 32'h1, "kept");
            apb(1'b1, a, 32'ha5a5_1234 + 32'(i));
            rd(a, 32'h1234 + 32'(i), "upper bits");
        end
        $display("test clamp done");
    endtask

    task automatic t_locked;
        @(posedge clock);
        enable <= 1'b1;
        apb(1'b1, STD_SCL_LOW_COUNT_ADDR, 32'h40);
        rd(STD_SCL_LOW_COUNT_ADDR, 32'h1235, "locked");
        apb(1'b1, FAST_SCL_HIGH_COUNT_ADDR, 32'h7);
        rd(FAST_SCL_HIGH_COUNT_ADDR, 32'h1236, "locked");
        rd(32'h5000_1324, 32'h0, "unmapped");
        chk({30'h0, pready, rerr}, 32'h3, "unmapped error");
        enable <= 1'b0;
        $display("test locked done");
    endtask

    // Runs the master and times two low phases in the chosen speed.
    task automatic t_phase(input logic f, input logic h, input int exp, input string msg);
        int n;
        @(posedge clock);
        fast <= f;
        hs <= h;
        enable <= 1'b1;
        active <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (scl_oe !== 1'b1 && n < 200) begin
                @(posedge clock);
                n++;
            end
            n = 0;
            while (scl_oe === 1'b1 && n < 300) begin
                @(posedge clock);
                n++;
            end
            chk(32'(n), 32'(exp), msg);
            chk({31'h0, scl_out}, 32'h0, "scl out");
        end
        enable <= 1'b0;
        active <= 1'b0;
        fast <= 1'b0;
        hs <= 1'b0;
        repeat (30) @(posedge clock);
        $display("test phase done");
    endtask

    // Threshold is std high 6 plus 10, plus sync, flag and foreign release slack.
    task automatic t_idle;
        int n;
        @(posedge clock);
        foreign <= 1'b1;
        repeat (20) @(posedge clock);
        chk({31'h0, bus_idle}, 32'h0, "busy");
        foreign <= 1'b0;
        n = 0;
        while (bus_idle !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, (n >= 16 && n <= 24)}, 32'h1, "idle delay");
        $display("test idle done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        {psel, penable, pwrite, enable, active, fast, hs, foreign, paddr, pwdata} = '0;
        {err_count, comparisons} = '0;
        rst_n = 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_clamp();
        t_locked();
        apb(1'b1, STD_SCL_HIGH_COUNT_ADDR, 32'h6);
        apb(1'b1, STD_SCL_LOW_COUNT_ADDR, 32'hc);
        apb(1'b1, FAST_SCL_HIGH_COUNT_ADDR, 32'h6);
        apb(1'b1, FAST_SCL_LOW_COUNT_ADDR, 32'h9);
        t_phase(1'b0, 1'b0, 12, "std low phase");
        t_phase(1'b1, 1'b0, 9, "fast low phase");
        t_phase(1'b0, 1'b1, 9, "preamble low phase");
        t_idle();
        tally_and_finish();
    end

    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
endmodule // scl_period_top_tb
`default_nettype wire
